// ### idmr_defs.svh
`ifndef IDMR_DEFS_SVH
`define IDMR_DEFS_SVH

`define IDMR_ADDR_POS2_LO 8'h63
`define IDMR_ADDR_IN2N_HI 8'h64
`define IDMR_ADDR_IN2N_LO 8'h65
`define IDMR_ADDR_POS3_HI 8'h66
`define IDMR_ADDR_POS3_LO 8'h67
`define IDMR_ADDR_IN3N_HI 8'h68
`define IDMR_ADDR_IN3N_LO 8'h69
`define IDMR_ADDR_POS4_HI 8'h6a
`define IDMR_ADDR_POS4_LO 8'h6b

`define IDMR_TAG_POS2 4'h4
`define IDMR_TAG_IN2N 4'h5
`define IDMR_TAG_POS3 4'h6
`define IDMR_TAG_IN3N 4'h7
`define IDMR_TAG_POS4 4'h8

`define IDMR_HI_RESET 8'h00
`define IDMR_NIB_RESET 4'h0
`define IDMR_NUM_CH 5

`endif

// ### idmr_pkg.sv
package idmr_pkg;
    // One 12-bit diagnostic result for one channel
    typedef struct packed {
        logic [7:0] upper_byte;
        logic [3:0] lower_nibble;
    } idmr_result_t;

    // Register access port request, read or write
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
    } idmr_req_t;

    // Channel index, in register order
    typedef enum logic [2:0] {
        IDMR_CH_POS2 = 3'h0,
        IDMR_CH_IN2N = 3'h1,
        IDMR_CH_POS3 = 3'h2,
        IDMR_CH_IN3N = 3'h3,
        IDMR_CH_POS4 = 3'h4
    } idmr_ch_t;
endpackage

// ### idmr_channel.sv
`include "idmr_defs.svh"

module idmr_channel
    import idmr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Measurement input
    input wire logic meas_valid,
    input wire idmr_result_t meas_data,
    // Held result
    output idmr_result_t result
);

    idmr_result_t result_r;

    // Both fields load in the same edge from one sample
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            result_r <= '{upper_byte: `IDMR_HI_RESET, lower_nibble: `IDMR_NIB_RESET};
        end else if (meas_valid) begin
            result_r <= meas_data;
        end
    end

    assign result = result_r;

    a_coherent_load: assert property (@(posedge clock) disable iff (!arst_n)
        meas_valid |=> result == $past(meas_data))
        else $error("result did not load whole measurement");

    a_hold_idle: assert property (@(posedge clock) disable iff (!arst_n)
        !meas_valid |=> $stable(result))
        else $error("result changed without a measurement");

endmodule // idmr_channel

// ### idmr_bank.sv
`include "idmr_defs.svh"

// Contract
// - 0x63 reads input-2-positive low nibble in 7-4, tag 0100b in 3-0.
// - 0x64 reads input-2-negative upper result byte, zero after reset.
// - 0x65 reads input-2-negative low nibble and tag 0101b.
// - 0x66 reads input-3-positive upper result byte, zero after reset.
// - 0x67 reads input-3-positive low nibble and tag 0110b.
// - 0x68 reads input-3-negative upper result byte, zero after reset.
// - 0x69 reads input-3-negative low nibble and tag 0111b.
// - 0x6A reads input-4-positive upper result byte, zero after reset.
// - 0x6B reads input-4-positive low nibble and tag 1000b.
module idmr_bank
    import idmr_pkg::*;
#(
    parameter int NUM_CH = `IDMR_NUM_CH
) (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Measurements from the converter, one strobe per channel
    input wire logic [NUM_CH-1:0] meas_valid,
    input wire idmr_result_t [NUM_CH-1:0] meas_data,
    // Control port register access
    input wire idmr_req_t req,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic hit
);

    ////////////////////////////////////////////////////////////////////////
    // Per-channel result holders

    idmr_result_t [NUM_CH-1:0] res;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        idmr_channel u_ch (
            .clock(clock),
            .arst_n(arst_n),
            .meas_valid(meas_valid[g]),
            .meas_data(meas_data[g]),
            .result(res[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode

    function automatic logic [7:0] low_tag(input idmr_result_t r, input logic [3:0] tag);
        return {r.lower_nibble, tag};
    endfunction

    logic [7:0] rd_mux;
    logic rd_map;

    always_comb begin
        rd_map = 1'b1;
        case (req.addr)
            `IDMR_ADDR_POS2_LO: rd_mux = low_tag(res[IDMR_CH_POS2], `IDMR_TAG_POS2);
            `IDMR_ADDR_IN2N_HI: rd_mux = res[IDMR_CH_IN2N].upper_byte;
            `IDMR_ADDR_IN2N_LO: rd_mux = low_tag(res[IDMR_CH_IN2N], `IDMR_TAG_IN2N);
            `IDMR_ADDR_POS3_HI: rd_mux = res[IDMR_CH_POS3].upper_byte;
            `IDMR_ADDR_POS3_LO: rd_mux = low_tag(res[IDMR_CH_POS3], `IDMR_TAG_POS3);
            `IDMR_ADDR_IN3N_HI: rd_mux = res[IDMR_CH_IN3N].upper_byte;
            `IDMR_ADDR_IN3N_LO: rd_mux = low_tag(res[IDMR_CH_IN3N], `IDMR_TAG_IN3N);
            `IDMR_ADDR_POS4_HI: rd_mux = res[IDMR_CH_POS4].upper_byte;
            `IDMR_ADDR_POS4_LO: rd_mux = low_tag(res[IDMR_CH_POS4], `IDMR_TAG_POS4);
            default: begin
                rd_map = 1'b0;
                rd_mux = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data register; write data is never stored

    logic [7:0] rdata_r;
    logic hit_r;
    wire logic wr_seen = req.wr && |wdata;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 8'h00;
            hit_r <= 1'b0;
        end else if (req.rd) begin
            rdata_r <= rd_mux;
            hit_r <= rd_map;
        end
    end

    assign rdata = rdata_r;
    assign hit = hit_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_pos2_tag: assert property (@(posedge clock) disable iff (!arst_n)
        req.rd && req.addr == `IDMR_ADDR_POS2_LO
        |=> rdata == {$past(res[IDMR_CH_POS2].lower_nibble), 4'h4} && hit)
        else $error("0x63 tag wrong");
    a_in2n_hi: assert property (@(posedge clock) disable iff (!arst_n)
        req.rd && req.addr == `IDMR_ADDR_IN2N_HI
        |=> rdata == $past(res[IDMR_CH_IN2N].upper_byte))
        else $error("0x64 byte wrong");
    a_in2n_lo: assert property (@(posedge clock) disable iff (!arst_n)
        req.rd && req.addr == `IDMR_ADDR_IN2N_LO
        |=> rdata == {$past(res[IDMR_CH_IN2N].lower_nibble), 4'h5})
        else $error("0x65 value wrong");
    a_pos3_hi: assert property (@(posedge clock) disable iff (!arst_n)
        req.rd && req.addr == `IDMR_ADDR_POS3_HI
        |=> rdata == $past(res[IDMR_CH_POS3].upper_byte))
        else $error("0x66 byte wrong");
    a_pos3_lo: assert property (@(posedge clock) disable iff (!arst_n)
        req.rd && req.addr == `IDMR_ADDR_POS3_LO
        |=> rdata == {$past(res[IDMR_CH_POS3].lower_nibble), 4'h6})
        else $error("0x67 value wrong");
    a_in3n_hi: assert property (@(posedge clock) disable iff (!arst_n)
        req.rd && req.addr == `IDMR_ADDR_IN3N_HI
        |=> rdata == $past(res[IDMR_CH_IN3N].upper_byte))
        else $error("0x68 byte wrong");
    a_in3n_lo: assert property (@(posedge clock) disable iff (!arst_n)
        req.rd && req.addr == `IDMR_ADDR_IN3N_LO
        |=> rdata == {$past(res[IDMR_CH_IN3N].lower_nibble), 4'h7})
        else $error("0x69 value wrong");
    a_pos4_hi: assert property (@(posedge clock) disable iff (!arst_n)
        req.rd && req.addr == `IDMR_ADDR_POS4_HI
        |=> rdata == $past(res[IDMR_CH_POS4].upper_byte))
        else $error("0x6a byte wrong");
    a_pos4_lo: assert property (@(posedge clock) disable iff (!arst_n)
        req.rd && req.addr == `IDMR_ADDR_POS4_LO
        |=> rdata == {$past(res[IDMR_CH_POS4].lower_nibble), 4'h8})
        else $error("0x6b value wrong");
    a_write_ignored: assert property (@(posedge clock) disable iff (!arst_n)
        req.wr && !req.rd && !(|meas_valid) |=> $stable(res) && $stable(rdata))
        else $error("write changed the bank");

    c_read_hit: cover property (@(posedge clock) disable iff (!arst_n)
        req.rd ##1 hit);
    c_read_miss: cover property (@(posedge clock) disable iff (!arst_n)
        req.rd ##1 !hit);
    c_meas_then_read: cover property (@(posedge clock) disable iff (!arst_n)
        meas_valid[IDMR_CH_IN3N] ##1 req.rd && req.addr == `IDMR_ADDR_IN3N_HI);
    c_write_data: cover property (@(posedge clock) disable iff (!arst_n) wr_seen);

endmodule // idmr_bank

// ### tb.sv
`include "idmr_defs.svh"

module tb
    import idmr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] meas_valid = 5'h00;
    idmr_result_t [4:0] meas_data = '0;
    idmr_req_t req = '0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic hit;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    idmr_result_t exp_r [5];

    idmr_bank dut (
        .clock(clock), .arst_n(arst_n), .meas_valid(meas_valid), .meas_data(meas_data),
        .req(req), .wdata(wdata), .rdata(rdata), .hit(hit)
    );

    always #4 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            $display("[ERR] %0t run did not finish in time", $time);
            tally_and_finish();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t rdata %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t hit %b expected %b", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Read stays requested until idle, answer checked one cycle on
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
        @(negedge clock);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clock);
        chk8(rdata, exp);
        chk1(hit, exp_hit);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        req = '{rd: 1'b0, wr: 1'b1, addr: a};
        wdata = d;
        @(negedge clock);
        req.wr = 1'b0;
    endtask

    task automatic meas(input int i, input logic [11:0] v);
        @(negedge clock);
        meas_valid[i] = 1'b1;
        meas_data[i] = v;
        exp_r[i] = v;
        @(negedge clock);
        meas_valid = 5'h00;
    endtask

    // Walk 0x62..0x6c, both ends unmapped
    task automatic sweep();
        logic [7:0] e;
        logic h;
        int ch;
        for (int a = 8'h62; a <= 8'h6c; a++) begin
            h = (a >= 8'h63 && a <= 8'h6b);
            ch = (a - 8'h62) / 2;
            e = 8'h00;
            if (h && a[0]) begin
                e = {exp_r[ch].lower_nibble, 4'(4'h4 + ch)};
            end else if (h) begin
                e = exp_r[ch].upper_byte;
            end
            rd(8'(a), e, h);
        end
        @(negedge clock);
        req.rd = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 5; i++) begin
            exp_r[i] = '0;
        end
        repeat (6) @(negedge clock);
        chk8(rdata, 8'h00);
        chk1(hit, 1'b0);
        arst_n = 1'b1;
        sweep();
        rd(8'h00, 8'h00, 1'b0);
        rd(8'hff, 8'h00, 1'b0);
        for (int i = 0; i < 5; i++) begin
            meas(i, 12'(12'h5a3 + 12'h111 * i));
        end
        for (int a = 8'h62; a <= 8'h6c; a++) begin
            wr(8'(a), 8'hff);
        end
        sweep();
        meas(4, 12'hfff);
        meas(1, 12'habc);
        rd(8'h64, 8'hab, 1'b1);
        rd(8'h65, 8'hc5, 1'b1);
        rd(8'h6b, 8'hf8, 1'b1);
        @(negedge clock);
        arst_n = 1'b0;
        req.rd = 1'b0;
        for (int i = 0; i < 5; i++) begin
            exp_r[i] = '0;
        end
        @(negedge clock);
        arst_n = 1'b1;
        sweep();
        tally_and_finish();
    end
endmodule // tb
